// ===== logic/crc_capture_reload_control.v
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
`include "crc_consts.vh"
module crc_capture_reload_control (
   // ahb-lite
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // capture pins
   input wire [2:0] cap_pin,
   // decoder status inputs, asynchronous
   input wire direction_index,
   input wire counter_overflow,
   input wire counter_underflow,
   input wire counter_wrap,
   input wire timer_overflow,
   // outputs
   output reg [2:0] capture_event,
   output reg reload_event,
   output reg irq
);
   reg [7:0] ctrl0_reg;
   reg [5:3] filt_reg;
   reg [2:0] flag_reg;
   reg [7:0] stat_reg;
   reg [7:0] mask_reg;
   reg [7:0] mode_reg;
   reg wr_pend_reg;
   reg [11:0] addr_reg;
   reg dir_prev_reg;
   reg ovf_prev_reg;
   reg unf_prev_reg;
   reg wrap_prev_reg;
   reg tmr_prev_reg;
   wire [2:0] edge_hit;
   wire dir_s;
   wire ovf_s;
   wire unf_s;
   wire wrap_s;
   wire tmr_s;
   wire rd_req;
   wire decoder_mode;
   wire dir_evt;
   wire dec_evt;
   wire reload_src;
   reg reload_hit;
   reg [2:0] flag_set;
   reg [2:0] flag_next;
   reg [7:0] stat_next;
   reg [31:0] rdata_next;
   wire addr_phase;
   wire wr_ctrl0;
   wire wr_ctrl1;
   wire wr_mask;
   wire wr_mode;
   wire rd_stat;
   wire dir_chg;
   wire ovf_rise;
   wire unf_rise;
   wire wrap_rise;
   wire tmr_rise;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gen_ch
         crc_edge_detect u_edge (
            .hclk(hclk),
            .hresetn(hresetn),
            .edge_sel(ctrl0_reg[2*g+3:2*g+2]),
            .filter_en(filt_reg[`CRC_F_CHAN0_FILTER_ENABLE+g]),
            .pin_in(cap_pin[g]),
            .edge_pulse(edge_hit[g])
         );
      end
   endgenerate

   // status lines come from another domain, so each passes two flops first
   crc_sync u_sdir (
      .hclk(hclk),
      .hresetn(hresetn),
      .d_in(direction_index),
      .q_out(dir_s)
   );

   crc_sync u_sovf (
      .hclk(hclk),
      .hresetn(hresetn),
      .d_in(counter_overflow),
      .q_out(ovf_s)
   );

   crc_sync u_sunf (
      .hclk(hclk),
      .hresetn(hresetn),
      .d_in(counter_underflow),
      .q_out(unf_s)
   );

   crc_sync u_swrap (
      .hclk(hclk),
      .hresetn(hresetn),
      .d_in(counter_wrap),
      .q_out(wrap_s)
   );

   crc_sync u_stmr (
      .hclk(hclk),
      .hresetn(hresetn),
      .d_in(timer_overflow),
      .q_out(tmr_s)
   );

   // one accepted address phase per transfer
   assign addr_phase = hsel & hready & htrans[1];
   assign rd_req = addr_phase & ~hwrite;
   assign rd_stat = rd_req & (haddr == `CRC_ADDR_IRQ_STAT);
   // writes land in the data phase, when hwdata stands
   assign wr_ctrl0 = wr_pend_reg & (addr_reg == `CRC_ADDR_CTRL0);
   assign wr_ctrl1 = wr_pend_reg & (addr_reg == `CRC_ADDR_CTRL1);
   assign wr_mask = wr_pend_reg & (addr_reg == `CRC_ADDR_IRQ_MASK);
   assign wr_mode = wr_pend_reg & (addr_reg == `CRC_ADDR_MODE);

   // edges of the synchronised status lines
   assign dir_chg = dir_s ^ dir_prev_reg;
   assign ovf_rise = ovf_s & ~ovf_prev_reg;
   assign unf_rise = unf_s & ~unf_prev_reg;
   assign wrap_rise = wrap_s & ~wrap_prev_reg;
   assign tmr_rise = tmr_s & ~tmr_prev_reg;

   assign decoder_mode = mode_reg[`CRC_M_DECODER];
   assign dir_evt = decoder_mode & mode_reg[`CRC_M_DIR_IE] & dir_chg;
   assign dec_evt = decoder_mode & (mode_reg[`CRC_M_COMPARE] ? wrap_rise : (ovf_rise | unf_rise));
   assign reload_src = tmr_rise;

   always @* begin
      case (ctrl0_reg[`CRC_F_RLD_LO+1:`CRC_F_RLD_LO])
         `CRC_RLD_TIMER: reload_hit = reload_src;
         `CRC_RLD_CAP0: reload_hit = edge_hit[0];
         `CRC_RLD_CAP1: reload_hit = edge_hit[1];
         `CRC_RLD_CAP2: reload_hit = edge_hit[2];
         default: reload_hit = 1'b0;
      endcase
   end

   always @* begin
      flag_set[`CRC_F_FLAG2] = edge_hit[2];
      flag_set[`CRC_F_FLAG1] = decoder_mode ? dir_evt : edge_hit[1];
      flag_set[`CRC_F_FLAG0] = decoder_mode ? dec_evt : edge_hit[0];
      flag_next = flag_reg;
      if (wr_ctrl1)
         flag_next = hwdata[2:0];
      flag_next = flag_next | flag_set;
      stat_next = stat_reg;
      // a read clears, but an event in the same cycle still lands
      if (rd_stat)
         stat_next = 8'h00;
      stat_next = stat_next | {4'h0, reload_hit, flag_set};
   end

   always @* begin
      rdata_next = 32'h0000_0000;
      case (haddr)
         `CRC_ADDR_CTRL0: rdata_next[7:0] = ctrl0_reg;
         `CRC_ADDR_CTRL1: rdata_next[7:0] = {2'b00, filt_reg, flag_reg};
         `CRC_ADDR_IRQ_STAT: rdata_next[7:0] = stat_reg;
         `CRC_ADDR_IRQ_MASK: rdata_next[7:0] = mask_reg;
         `CRC_ADDR_MODE: rdata_next[7:0] = mode_reg;
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // bus phase tracking; the slave never stretches a transfer
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 12'h000;
      end else begin
         wr_pend_reg <= addr_phase & hwrite;
         if (addr_phase)
            addr_reg <= haddr;
      end
   end

   // read data latched at the address phase, so it stands in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else begin
         if (rd_req)
            hrdata <= rdata_next;
      end
   end

   // zero wait states, always okay
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl0_reg <= `CRC_RST_CTRL0;
      end else begin
         if (wr_ctrl0)
            ctrl0_reg <= hwdata[7:0];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filt_reg <= `CRC_RST_FILT;
      end else begin
         if (wr_ctrl1)
            filt_reg <= hwdata[5:3];
      end
   end

   // interrupt mask, same layout as status
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_reg <= `CRC_RST_MASK;
      end else begin
         if (wr_mask)
            mask_reg <= hwdata[7:0];
      end
   end

   // decoder mode, counting mode, direction interrupt enable
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg <= `CRC_RST_MODE;
      end else begin
         if (wr_mode)
            mode_reg <= {5'b00000, hwdata[2:0]};
      end
   end

   // previous samples; reset matches the idle low lines so no false edge follows
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_prev_reg <= 1'b0;
      end else begin
         dir_prev_reg <= dir_s;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovf_prev_reg <= 1'b0;
      end else begin
         ovf_prev_reg <= ovf_s;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unf_prev_reg <= 1'b0;
      end else begin
         unf_prev_reg <= unf_s;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wrap_prev_reg <= 1'b0;
      end else begin
         wrap_prev_reg <= wrap_s;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tmr_prev_reg <= 1'b0;
      end else begin
         tmr_prev_reg <= tmr_s;
      end
   end

   // flags held until software writes them
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_reg <= `CRC_RST_FLAG;
      end else begin
         flag_reg <= flag_next;
      end
   end

   // sticky interrupt status
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_reg <= `CRC_RST_STAT;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // registered one-cycle event outputs
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capture_event <= 3'b000;
      end else begin
         capture_event <= edge_hit;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reload_event <= 1'b0;
      end else begin
         reload_event <= reload_hit;
      end
   end

   // irq built from the next status so it rises together with the flag
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_next & mask_reg);
      end
   end
endmodule

// ===== logic/crc_consts.vh
// Behaviour
// - two-bit edge select per channel at bits 7-6, 5-4, 3-2; 11 reserved
// - reload trigger field bits 1-0: timer overflow or capture block 0, 1, 2
// - filter enables for inputs 2, 1, 0 at bits 5, 4, 3 of second control
// - bit 2 of second control is channel 2 event flag
// - in capture mode bit 1 is channel 1 event flag
// - in decoder mode bit 1 sets on direction change when enabled
// - direction flag is never cleared by hardware, only by software
// - bit 0 is channel 0 flag in capture mode, decoder flag otherwise
// - free-counting mode: counter overflow or underflow sets decoder flag
// - compare-counting mode: wrap max to zero or zero to max sets decoder flag
`ifndef CRC_CONSTS_VH
`define CRC_CONSTS_VH
`define CRC_IDX_CTRL0 8'ha3
`define CRC_IDX_CTRL1 8'ha4
`define CRC_IDX_IRQ_STAT 8'ha5
`define CRC_IDX_IRQ_MASK 8'ha6
`define CRC_IDX_MODE 8'ha7
`define CRC_ADDR_CTRL0 12'h28c
`define CRC_ADDR_CTRL1 12'h290
`define CRC_ADDR_IRQ_STAT 12'h294
`define CRC_ADDR_IRQ_MASK 12'h298
`define CRC_ADDR_MODE 12'h29c
`define CRC_RST_CTRL0 8'h00
`define CRC_RST_CTRL1 8'h00
`define CRC_RST_MASK 8'h00
`define CRC_RST_MODE 8'h00
`define CRC_RST_FILT 3'b000
`define CRC_RST_FLAG 3'b000
`define CRC_RST_STAT 8'h00
`define CRC_EDGE_RISE 2'b00
`define CRC_EDGE_FALL 2'b01
`define CRC_EDGE_BOTH 2'b10
`define CRC_RLD_TIMER 2'b00
`define CRC_RLD_CAP0 2'b01
`define CRC_RLD_CAP1 2'b10
`define CRC_RLD_CAP2 2'b11
`define CRC_F_RLD_LO 0
`define CRC_F_CHAN0_FILTER_ENABLE 3
`define CRC_F_FLAG0 0
`define CRC_F_FLAG1 1
`define CRC_F_FLAG2 2
`define CRC_M_DECODER 0
`define CRC_M_COMPARE 1
`define CRC_M_DIR_IE 2
`define CRC_FILT_LEN 3
`endif

// ===== logic/crc_edge_detect.v
`timescale 1ns/10ps
`include "crc_consts.vh"
module crc_edge_detect (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // control
   input wire [1:0] edge_sel,
   input wire filter_en,
   // pin
   input wire pin_in,
   // event
   output reg edge_pulse
);
   reg sync1_reg;
   reg sync2_reg;
   reg [`CRC_FILT_LEN-1:0] hist_reg;
   reg level_reg;
   reg prev_reg;
   wire stable_hi;
   wire stable_lo;
   wire cur;
   wire rise;
   wire fall;
   assign stable_hi = &hist_reg;
   assign stable_lo = ~|hist_reg;
   // unfiltered path still passes both synchroniser stages
   assign cur = filter_en ? level_reg : sync2_reg;
   assign rise = cur & ~prev_reg;
   assign fall = ~cur & prev_reg;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         hist_reg <= {`CRC_FILT_LEN{1'b0}};
         level_reg <= 1'b0;
         prev_reg <= 1'b0;
         edge_pulse <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         hist_reg <= {hist_reg[`CRC_FILT_LEN-2:0], sync2_reg};
         if (stable_hi)
            level_reg <= 1'b1;
         else if (stable_lo)
            level_reg <= 1'b0;
         prev_reg <= cur;
         case (edge_sel)
            `CRC_EDGE_RISE: edge_pulse <= rise;
            `CRC_EDGE_FALL: edge_pulse <= fall;
            `CRC_EDGE_BOTH: edge_pulse <= rise | fall;
            default: edge_pulse <= 1'b0;
         endcase
      end
   end
endmodule

// ===== logic/crc_sync.v
`timescale 1ns/10ps
module crc_sync (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // async level in, synchronised out
   input wire d_in,
   output reg q_out
);
   reg s1_reg;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_reg <= 1'b0;
         q_out <= 1'b0;
      end else begin
         s1_reg <= d_in;
         q_out <= s1_reg;
      end
   end
endmodule

// ===== bench/crc_assertions.sv
`timescale 1ns/10ps
module crc_assertions (
   // bus
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // pins
   input wire [2:0] cap_pin,
   input wire direction_index,
   input wire counter_overflow,
   input wire counter_underflow,
   input wire counter_wrap,
   input wire timer_overflow,
   // results
   input wire [2:0] capture_event,
   input wire reload_event,
   input wire irq
);
   wire [7:0] ins = {timer_overflow, counter_wrap, counter_underflow, counter_overflow, direction_index, cap_pin};
   reg [7:0] ins_d;
   reg [4:0] c_act;
   reg [4:0] c_bus;
   // saturating ages of the last input move and the last transfer
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ins_d <= 8'h00;
         c_act <= 5'h1f;
         c_bus <= 5'h1f;
      end else begin
         ins_d <= ins;
         c_act <= (ins != ins_d) ? 5'h00 : ((&c_act) ? c_act : c_act + 5'h01);
         c_bus <= (hsel && htrans[1]) ? 5'h00 : ((&c_bus) ? c_bus : c_bus + 5'h01);
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_READY: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h00_0000)
      else $error("bus answer not zero-wait okay");
   AST_CAP_CAUSE: assert property (|capture_event |-> c_act <= 5'h0c)
      else $error("capture event without input edge");
   AST_CAP_PULSE: assert property (capture_event[0] |=> !capture_event[0])
      else $error("capture event longer than one cycle");
   AST_RLD_CAUSE: assert property (reload_event |-> c_act <= 5'h0c)
      else $error("reload without a source event");
   AST_RLD_PULSE: assert property (reload_event |=> !reload_event)
      else $error("reload longer than one cycle");
   AST_IRQ_FALL: assert property ($fell(irq) |-> c_bus < 5'h06)
      else $error("irq dropped without software access");
   AST_IRQ_RISE: assert property ($rose(irq) |-> (c_bus < 5'h06 || c_act < 5'h10))
      else $error("irq rose without a cause");
   AST_IRQ_HOLD: assert property (irq && c_bus > 5'h06 && !(hsel && htrans[1]) |=> irq)
      else $error("irq fell while bus idle");
endmodule

// ===== bench/crc_partner.sv
`timescale 1ns/10ps
module crc_partner (
   // clock
   input wire hclk,
   // one toggle request per line
   input wire [7:0] tog,
   // lines toward the block
   output reg [2:0] cap_pin,
   output reg direction_index,
   output reg counter_overflow,
   output reg counter_underflow,
   output reg counter_wrap,
   output reg timer_overflow
);
   wire [7:0] cur = {timer_overflow, counter_wrap, counter_underflow, counter_overflow, direction_index, cap_pin};
   initial {timer_overflow, counter_wrap, counter_underflow, counter_overflow, direction_index, cap_pin} = 8'h00;
   always @(posedge hclk) begin
      {timer_overflow, counter_wrap, counter_underflow, counter_overflow, direction_index, cap_pin} <= cur ^ tog;
   end
endmodule

// ===== bench/crc_capture_reload_control_bench.sv
`timescale 1ns/10ps
`include "crc_consts.vh"
module crc_capture_reload_control_bench;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg hsel = 1'b0;
   reg [11:0] haddr = 12'h000;
   reg [1:0] htrans = 2'b00;
   reg hwrite = 1'b0;
   reg [2:0] hsize = 3'h2;
   reg [31:0] hwdata = 32'h0000_0000;
   reg [7:0] tog = 8'h00;
   reg rd_ph = 1'b0;
   reg [7:0] c;
   wire [31:0] hrdata;
   wire hreadyout, hresp, direction_index, counter_overflow, counter_underflow, counter_wrap, timer_overflow;
   wire [2:0] cap_pin;
   wire [2:0] capture_event;
   wire reload_event, irq;
   logic [31:0] q[$];
   int n_mismatch = 0;
   int n_compared = 0;
   int cnt[4] = '{0, 0, 0, 0};
   int base[4];
   int e, f;
   crc_capture_reload_control crc_capture_reload_control_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cap_pin, .direction_index,
      .counter_overflow, .counter_underflow, .counter_wrap, .timer_overflow, .capture_event, .reload_event, .irq);
   crc_partner crc_partner_i (.hclk, .tog, .cap_pin, .direction_index, .counter_overflow, .counter_underflow,
      .counter_wrap, .timer_overflow);
   initial begin
      forever #25 hclk = ~hclk;
   end
   task end_of_test;
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input [31:0] s, input [31:0] x);
      n_compared++;
      if (s !== x) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h want %h", $time, s, x);
      end
   endtask
   // bounded wait for hready at a rising edge
   task wt;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         end_of_test;
      end
   endtask
   task xf(input [11:0] a, input w, input [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      wt;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_ph <= !w;
      wt;
      rd_ph <= 1'b0;
   endtask
   task rd(input [11:0] a, input [31:0] x);
      q.push_back(x);
      xf(a, 1'b0, 32'h0000_0000);
   endtask
   task wr(input [11:0] a, input [31:0] d);
      xf(a, 1'b1, d);
   endtask
   task tp(input int b);
      tog <= 8'h01 << b;
      @(posedge hclk);
      tog <= 8'h00;
      repeat (20) @(posedge hclk);
   endtask
   task ck_irq(input x);
      // irq is registered after the flag or mask update lands
      repeat (2) @(posedge hclk);
      chk(irq, x);
   endtask
   always @(posedge hclk) begin
      if (rd_ph === 1'b1)
         chk(hrdata, q.pop_front());
      for (int i = 0; i < 3; i++)
         cnt[i] += (capture_event[i] === 1'b1);
      cnt[3] += (reload_event === 1'b1);
   end
   initial begin
      #400000;
      n_mismatch++;
      end_of_test;
   end
   initial begin
      void'($urandom(32'h2786_d94b));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`CRC_ADDR_CTRL0, `CRC_RST_CTRL0);
      rd(`CRC_ADDR_CTRL1, `CRC_RST_CTRL1);
      rd(`CRC_ADDR_IRQ_MASK, `CRC_RST_MASK);
      rd(`CRC_ADDR_MODE, `CRC_RST_MODE);
      wr(12'h000, $urandom);
      rd(12'h000, 32'h0000_0000);
      f = $urandom & 7;
      wr(`CRC_ADDR_CTRL1, f << 3);
      rd(`CRC_ADDR_CTRL1, f << 3);
      wr(`CRC_ADDR_IRQ_MASK, 32'h0000_000f);
      // reserved edge code 11 is never written
      for (e = 0; e < 3; e++) begin
         c = {e[1:0], e[1:0], e[1:0], e[1:0] + 2'b01};
         wr(`CRC_ADDR_CTRL0, c);
         rd(`CRC_ADDR_CTRL0, c);
         base = cnt;
         for (int i = 0; i < 6; i++)
            tp(i / 2);
         for (int i = 0; i < 4; i++)
            chk(cnt[i] - base[i], (e == 2) ? 2 : 1);
         rd(`CRC_ADDR_CTRL1, (f << 3) | 7);
         ck_irq(1'b1);
         rd(`CRC_ADDR_IRQ_STAT, 32'h0000_000f);
         wr(`CRC_ADDR_CTRL1, f << 3);
         ck_irq(1'b0);
      end
      wr(`CRC_ADDR_IRQ_MASK, 32'h0000_0000);
      tp(0);
      ck_irq(1'b0);
      wr(`CRC_ADDR_IRQ_MASK, 32'h0000_0001);
      ck_irq(1'b1);
      rd(`CRC_ADDR_IRQ_STAT, 32'h0000_0001);
      ck_irq(1'b0);
      wr(`CRC_ADDR_CTRL0, `CRC_RLD_TIMER);
      wr(`CRC_ADDR_CTRL1, 32'h0000_0038);
      base = cnt;
      tp(7);
      tp(7);
      tog <= 8'h01;
      repeat (2) @(posedge hclk);
      tog <= 8'h00;
      repeat (20) @(posedge hclk);
      chk(cnt[3] - base[3], 1);
      chk(cnt[0] - base[0], 0);
      wr(`CRC_ADDR_MODE, 32'h0000_0005);
      wr(`CRC_ADDR_CTRL1, 32'h0000_0000);
      tp(3);
      tp(4);
      tp(4);
      rd(`CRC_ADDR_CTRL1, 32'h0000_0003);
      repeat (20) @(posedge hclk);
      rd(`CRC_ADDR_CTRL1, 32'h0000_0003);
      wr(`CRC_ADDR_CTRL1, 32'h0000_0000);
      tp(5);
      tp(5);
      rd(`CRC_ADDR_CTRL1, 32'h0000_0001);
      wr(`CRC_ADDR_CTRL1, 32'h0000_0000);
      wr(`CRC_ADDR_MODE, 32'h0000_0001);
      tp(3);
      rd(`CRC_ADDR_CTRL1, 32'h0000_0000);
      wr(`CRC_ADDR_MODE, 32'h0000_0003);
      tp(6);
      tp(6);
      rd(`CRC_ADDR_CTRL1, 32'h0000_0001);
      end_of_test;
   end
endmodule
bind crc_capture_reload_control crc_assertions crc_assertions_i (.hclk, .hresetn, .hsel, .htrans, .hrdata,
   .hreadyout, .hresp, .cap_pin, .direction_index, .counter_overflow, .counter_underflow, .counter_wrap,
   .timer_overflow, .capture_event, .reload_event, .irq);
